// ==== verilog/fbep_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "fbep_consts.vh"
module fbep_ctrl #(
    parameter AW = `FBEP_ADDR_W,
    parameter DW = `FBEP_DATA_W,
    parameter NUNITS = `FBEP_NUM_UNITS
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // protection setting, two bits per unit
    input wire [2*NUNITS-1:0] prot_set,
    input wire prot_wr,
    // instruction fetch
    input wire fetch_req,
    input wire [AW-1:0] fetch_addr,
    // data read (processor or debugger)
    input wire data_req,
    input wire [AW-1:0] data_addr,
    // program and erase
    input wire prog_req,
    input wire [AW-1:0] prog_addr,
    input wire [DW-1:0] prog_data,
    input wire erase_req,
    input wire [`FBEP_BLK_W-1:0] erase_blk,
    // answers
    output reg rd_valid_r,
    output reg [DW-1:0] rd_data_r,
    output reg busy_r,
    output reg done_r,
    output reg viol_r,
    output reg [1:0] viol_cause_r,
    output reg [2*NUNITS-1:0] prot_r
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ERASE = 2'h1;
    localparam ST_READ = 2'h2;
    localparam [`FBEP_WORD_IN_BLK_W-1:0] ECNT_LAST = {`FBEP_WORD_IN_BLK_W{1'b1}};

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`FBEP_BLK_W-1:0] eblk_r;
    reg [`FBEP_WORD_IN_BLK_W-1:0] ecnt_r;
    reg rd_pend_r;

    // unit index of a word address
    function [`FBEP_UNIT_W-1:0] unit_of;
        input [AW-1:0] a;
        begin
            unit_of = a[AW-1:`FBEP_UNIT_LSB];
        end
    endfunction

    // any code but none locks a unit against program and erase
    function code_wlock;
        input [1:0] c;
        begin
            code_wlock = (c != `FBEP_PROT_NONE);
        end
    endfunction

    // per-unit decode of the protection codes
    wire [NUNITS-1:0] unit_wlock;
    wire [NUNITS-1:0] unit_xonly;
    genvar gi;
    generate
        for (gi = 0; gi < NUNITS; gi = gi + 1) begin : g_unit
            assign unit_wlock[gi] = code_wlock(prot_r[2*gi +: 2]);
            assign unit_xonly[gi] = (prot_r[2*gi +: 2] == `FBEP_PROT_XO);
        end
    endgenerate

    wire idle = (state_r == ST_IDLE);
    wire [`FBEP_UNIT_W-1:0] erase_unit = erase_blk[`FBEP_BLK_W-1:1];

    // writes refused for both read-only and execute-only
    wire prog_deny = unit_wlock[unit_of(prog_addr)];
    wire erase_deny = unit_wlock[erase_unit];
    wire data_deny = unit_xonly[unit_of(data_addr)];

    // priority: fetch, data read, erase, program
    wire do_fetch = idle && fetch_req;
    wire do_data = idle && !fetch_req && data_req;
    wire do_erase = idle && !fetch_req && !data_req && erase_req;
    wire do_prog = idle && !fetch_req && !data_req && !erase_req && prog_req;

    // accepted and refused requests
    wire erase_go = do_erase && !erase_deny;
    wire erase_bad = do_erase && erase_deny;
    wire prog_go = do_prog && !prog_deny;
    wire prog_bad = do_prog && prog_deny;
    wire data_bad = do_data && data_deny;
    wire erase_last = (state_r == ST_ERASE) && (ecnt_r == ECNT_LAST);

    reg [AW-1:0] mem_waddr;
    reg [DW-1:0] mem_wdata;
    wire mem_wr = (state_r == ST_ERASE) || prog_go;
    wire mem_rd = do_fetch || (do_data && !data_deny);
    wire [AW-1:0] mem_raddr = do_fetch ? fetch_addr : data_addr;

    // erase walk owns the write port while it runs
    always @* begin
        if (state_r == ST_ERASE) begin
            mem_waddr = {eblk_r, ecnt_r};
            mem_wdata = `FBEP_ERASED;
        end else begin
            mem_waddr = prog_addr;
            mem_wdata = prog_data;
        end
    end
    wire [DW-1:0] mem_rdata;

    fbep_array #(
        .AW(AW),
        .DW(DW),
        .DEPTH(`FBEP_WORDS)
    ) u_array (
        .core_clk(core_clk),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_en(mem_rd),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (mem_rd) begin
                    state_nxt = ST_READ;
                end else if (erase_go) begin
                    state_nxt = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (erase_last) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_READ: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer state and erase walk
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            eblk_r <= {`FBEP_BLK_W{1'b0}};
            ecnt_r <= {`FBEP_WORD_IN_BLK_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            busy_r <= (state_nxt != ST_IDLE);
            if (erase_go) begin
                eblk_r <= erase_blk;
                ecnt_r <= {`FBEP_WORD_IN_BLK_W{1'b0}};
            end else if (state_r == ST_ERASE) begin
                ecnt_r <= ecnt_r + 1'b1;
            end
        end
    end

    // read return: array data is registered one edge after the take
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_r <= 1'b0;
            rd_valid_r <= 1'b0;
            rd_data_r <= `FBEP_ZERO32;
        end else begin
            rd_pend_r <= mem_rd;
            rd_valid_r <= rd_pend_r;
            // denied read drives zero data
            rd_data_r <= rd_pend_r ? mem_rdata : `FBEP_ZERO32;
        end
    end

    // protection setting
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prot_r <= {2*NUNITS{1'b0}};
        end else if (prot_wr) begin
            prot_r <= prot_set;
        end
    end

    // completion pulse for program and erase
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= erase_last || prog_go;
        end
    end

    // refusal pulse and its cause
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            viol_r <= 1'b0;
            viol_cause_r <= `FBEP_VIO_NONE;
        end else begin
            viol_r <= prog_bad || erase_bad || data_bad;
            if (prog_bad || erase_bad) begin
                viol_cause_r <= `FBEP_VIO_WRITE;
            end else if (data_bad) begin
                viol_cause_r <= `FBEP_VIO_READ;
            end else begin
                viol_cause_r <= `FBEP_VIO_NONE;
            end
        end
    end
endmodule
`default_nettype wire

// ==== shared/fbep_consts.vh ====
`ifndef FBEP_CONSTS_VH
`define FBEP_CONSTS_VH
// array geometry: 8 KB as 2048 words of 32 bits
`define FBEP_ADDR_W 11
`define FBEP_DATA_W 32
`define FBEP_WORDS 2048
// 1 KB erase block = 256 words, 2 KB protection unit = 512 words
`define FBEP_BLK_LSB 8
`define FBEP_BLK_W 3
`define FBEP_UNIT_LSB 9
`define FBEP_UNIT_W 2
`define FBEP_NUM_UNITS 4
`define FBEP_WORD_IN_BLK_W 8
// protection encodings
`define FBEP_PROT_NONE 2'h0
`define FBEP_PROT_RO 2'h1
`define FBEP_PROT_XO 2'h2
// erased value
`define FBEP_ERASED 32'hFFFFFFFF
`define FBEP_ZERO32 32'h00000000
// violation causes
`define FBEP_VIO_NONE 2'h0
`define FBEP_VIO_WRITE 2'h1
`define FBEP_VIO_READ 2'h2
`endif

// ==== verilog/fbep_array.v ====
`timescale 1ns/100ps
`default_nettype none
`include "fbep_consts.vh"
// flash word store with registered read data
module fbep_array #(
    parameter AW = `FBEP_ADDR_W,
    parameter DW = `FBEP_DATA_W,
    parameter DEPTH = `FBEP_WORDS
) (
    // clock
    input wire core_clk,
    // write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // read port
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:DEPTH-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ==== bench/fbep_ctrl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module fbep_ctrl_monitor #(parameter NUNITS = 4) (
    // watched ports
    input wire logic core_clk, rst_n, prot_wr, fetch_req, data_req, erase_req,
    input wire logic busy_r, rd_valid_r, done_r, viol_r,
    input wire logic [2:0] erase_blk,
    input wire logic [10:0] data_addr,
    input wire logic [31:0] rd_data_r,
    input wire logic [1:0] viol_cause_r,
    input wire logic [2*NUNITS-1:0] prot_set, prot_r
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire take = !busy_r && !fetch_req && !data_req;
    wire [1:0] ecode = prot_r[{erase_blk[2:1], 1'b0} +: 2];
    wire [1:0] dcode = prot_r[{data_addr[10:9], 1'b0} +: 2];
    a_data_quiet: assert property (!rd_valid_r |-> rd_data_r == 32'h0) else $error("stray data");
    a_cause_quiet: assert property (!viol_r |-> viol_cause_r == 2'h0) else $error("stray cause");
    a_prot_load: assert property (prot_wr |=> prot_r == $past(prot_set)) else $error("prot load");
    a_fetch_answer: assert property (fetch_req && !busy_r |=> busy_r ##1 rd_valid_r) else $error("fetch");
    a_erase_refuse: assert property (take && erase_req && ecode != 2'h0 |=> viol_r && viol_cause_r == 2'h1)
        else $error("erase passed");
    a_erase_time: assert property (take && erase_req && ecode == 2'h0 |-> ##257 done_r) else $error("erase len");
    a_erase_busy: assert property (take && erase_req && ecode == 2'h0 |=> busy_r [*8]) else $error("not busy");
    a_xo_read: assert property (!busy_r && !fetch_req && data_req && dcode == 2'h2 |=> viol_r && viol_cause_r == 2'h2)
        else $error("xo read");
endmodule
bind fbep_ctrl fbep_ctrl_monitor #(.NUNITS(NUNITS)) u_mon (.core_clk(core_clk), .rst_n(rst_n), .prot_wr(prot_wr),
    .fetch_req(fetch_req), .data_req(data_req), .erase_req(erase_req), .busy_r(busy_r), .rd_valid_r(rd_valid_r),
    .done_r(done_r), .viol_r(viol_r), .erase_blk(erase_blk), .data_addr(data_addr), .rd_data_r(rd_data_r),
    .viol_cause_r(viol_cause_r), .prot_set(prot_set), .prot_r(prot_r));
`default_nettype wire

// ==== bench/fbep_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module fbep_host (
    input wire logic core_clk,
    output logic [3:0] rq,
    output logic [10:0] a,
    output logic [31:0] d
);
    initial rq = 4'h0;
    // released address and data lines show the inverse so stale values never match; requests drop to zero
    task send(input logic [3:0] k, input logic [10:0] ad, input logic [31:0] dt);
        @(posedge core_clk);
        rq <= k;
        a <= ad;
        d <= dt;
        @(posedge core_clk);
        rq <= 4'h0;
        a <= ~ad;
        d <= ~dt;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk = 1'b0, rst_n = 1'b0, prot_wr = 1'b0;
    logic [7:0] prot_set = 8'h00, prot_r;
    logic [3:0] rq;
    logic [10:0] a;
    logic [31:0] d, rd_data_r;
    logic rd_valid_r, busy_r, done_r, viol_r;
    logic [1:0] viol_cause_r;
    int fails = 0, n_checks = 0, cyc = 0;
    always #12.5 core_clk = ~core_clk;
    fbep_host u_fbep_host (.core_clk(core_clk), .rq(rq), .a(a), .d(d));
    fbep_ctrl u_fbep_ctrl (.core_clk(core_clk), .rst_n(rst_n), .prot_set(prot_set), .prot_wr(prot_wr),
        .fetch_req(rq[0]), .fetch_addr(a), .data_req(rq[1]), .data_addr(a), .erase_req(rq[2]), .erase_blk(a[10:8]),
        .prog_req(rq[3]), .prog_addr(a), .prog_data(d), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
        .busy_r(busy_r), .done_r(done_r), .viol_r(viol_r), .viol_cause_r(viol_cause_r), .prot_r(prot_r));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // answer word: read data, or {viol, done, cause}
    task op(input logic [3:0] k, input logic [10:0] ad, input logic [31:0] dt, input logic [31:0] exp);
        logic [31:0] r;
        r = 32'h0;
        u_fbep_host.send(k, ad, dt);
        for (int i = 0; i < 300 && r === 32'h0; i++) begin
            @(negedge core_clk);
            if ((rd_valid_r | done_r | viol_r) === 1'b1)
                r = rd_valid_r ? rd_data_r : {28'h0, viol_r, done_r, viol_cause_r};
        end
        check(r, exp);
    endtask
    task set_prot(input logic [7:0] p);
        @(posedge core_clk);
        prot_set <= p;
        prot_wr <= 1'b1;
        @(posedge core_clk);
        prot_wr <= 1'b0;
        @(negedge core_clk);
        check({24'h0, prot_r}, {24'h0, p});
    endtask
    task t_erase;
        op(4'h8, 11'h010, 32'h12345678, 32'h4);
        op(4'h8, 11'h110, 32'h0BADF00D, 32'h4);
        op(4'h8, 11'h210, 32'hA5A5A5A5, 32'h4);
        op(4'h1, 11'h010, 32'h0, 32'h12345678);
        op(4'h4, 11'h000, 32'h0, 32'h4);
        op(4'h2, 11'h010, 32'h0, 32'hFFFFFFFF);
        op(4'h2, 11'h110, 32'h0, 32'h0BADF00D);
    endtask
    task t_read_only;
        set_prot(8'h01);
        op(4'h8, 11'h010, 32'h0, 32'h9);
        op(4'h4, 11'h100, 32'h0, 32'h9);
        op(4'h2, 11'h010, 32'h0, 32'hFFFFFFFF);
        op(4'h2, 11'h110, 32'h0, 32'h0BADF00D);
    endtask
    task t_exec_only;
        set_prot(8'h08);
        op(4'h2, 11'h210, 32'h0, 32'hA);
        op(4'h1, 11'h210, 32'h0, 32'hA5A5A5A5);
        op(4'h8, 11'h220, 32'h0, 32'h9);
        op(4'h4, 11'h500, 32'h0, 32'h4);
    endtask
    task stop_test;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        check({18'h0, busy_r, done_r, viol_r, rd_valid_r, viol_cause_r, prot_r}, 32'h0);
        t_erase();
        t_read_only();
        t_exec_only();
        stop_test();
    end
endmodule
`default_nettype wire
